// File: core/udart_pkg.sv
// Behaviour
// - Count is two cascaded bytes, sixteen bits.
// - Select bit picks divided clock or pin.
// - Count advances only while run bit set.
// - Three modes chosen by three control bits.
// - Down enable clear: classic up-count reload.
// - Up overflow at all-ones sets flag, interrupt.
// - Up overflow loads reload value in reload mode, zero in other modes.
// - Down underflow when count equals reload value.
// - Underflow sets flag and loads all-ones.
// - Toggle flag inverts on wrap in reload mode with down enable set, no interrupt.
package udart_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int         ADDR_W          = 4;
  localparam logic [3:0] ADDR_CONTROL    = 4'h0;
  localparam logic [3:0] ADDR_MODE       = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LOW  = 4'h2;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_RELOAD_LOW = 4'h4;
  localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h5;

  // ************************************************************
  // Control and mode register bit positions
  // ************************************************************
  localparam int CTL_OVF     = 7;
  localparam int CTL_TOGGLE  = 6;
  localparam int CTL_RCLK    = 5;
  localparam int CTL_TRANSMIT_CLOCK_SELECT    = 4;
  localparam int CTL_RUN     = 2;
  localparam int CTL_CT_SEL  = 1;
  localparam int CTL_CP_RL   = 0;
  localparam int CTL_RSVD    = 3;
  localparam int MODE_DOWN_COUNT_ENABLE   = 0;

  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] ALL_ONES    = 16'hffff;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam int          PRESCALE    = 12;

  typedef enum logic [1:0] {UDART_CAPTURE, UDART_RELOAD, UDART_BAUD} udart_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } udart_bus_t;

endpackage

// File: core/udart_timer.sv
`timescale 1ns/1ps
module udart_timer #(
  parameter int PRESCALE_DIV = udart_pkg::PRESCALE
) (
  // Clock and reset
  input  wire logic               CLOCK,
  input  wire logic               RST_B,
  // Register port
  input  wire udart_pkg::udart_bus_t BUS,
  output logic [7:0]              RDATA,
  // External pins
  input  wire logic               COUNT_PIN,
  input  wire logic               DIR_PIN,
  // Status outputs
  output logic                    IRQ,
  output logic [15:0]             COUNT
);
  import udart_pkg::*;

  // Below three the prescaler leaves fewer than two quiet cycles between ticks.
  if (PRESCALE_DIV < 3 || PRESCALE_DIV > 255) begin
    $error("PRESCALE_DIV out of range");
  end

  // One decode of a register write, shared by the logic and the checks.
  function automatic logic wr_hit(input udart_bus_t b, input logic [ADDR_W-1:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // ************************************************************
  // Pin synchronisers and edge detect
  // ************************************************************
  logic [1:0] cnt_sync_reg;
  logic [1:0] dir_sync_reg;
  logic       cnt_last_reg;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_sync_reg <= 2'h0;
      dir_sync_reg <= 2'h0;
      cnt_last_reg <= 1'b0;
    end else begin
      cnt_sync_reg <= {cnt_sync_reg[0], COUNT_PIN};
      dir_sync_reg <= {dir_sync_reg[0], DIR_PIN};
      cnt_last_reg <= cnt_sync_reg[1];
    end
  end
  // Falling edge on the pin is one count, as the classic counter input.
  logic pin_event;
  assign pin_event = cnt_last_reg & ~cnt_sync_reg[1];

  // ************************************************************
  // Prescaler
  // ************************************************************
  logic [7:0] pre_reg;
  logic       pre_tick;
  assign pre_tick = (pre_reg == 8'(PRESCALE_DIV - 1));
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      pre_reg <= 8'h00;
    end else if (pre_tick) begin
      pre_reg <= 8'h00;
    end else begin
      pre_reg <= pre_reg + 8'h01;
    end
  end

  // ************************************************************
  // Control state
  // ************************************************************
  logic [7:0]  ctl_reg;
  logic [7:0]  mode_reg;
  logic [15:0] reload_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        wrap;
  logic        up_dir;
  logic        step;
  udart_mode_t op_mode;

  always_comb begin
    if (ctl_reg[CTL_RCLK] | ctl_reg[CTL_TRANSMIT_CLOCK_SELECT]) begin
      op_mode = UDART_BAUD;
    end else if (ctl_reg[CTL_CP_RL]) begin
      op_mode = UDART_CAPTURE;
    end else begin
      op_mode = UDART_RELOAD;
    end
  end

  // Timer input is the divided clock, counter input is the pin.
  assign step = ctl_reg[CTL_RUN] & (ctl_reg[CTL_CT_SEL] ? pin_event : pre_tick);
  // Direction pin only matters with down enable set in reload mode.
  assign up_dir = !(op_mode == UDART_RELOAD && mode_reg[MODE_DOWN_COUNT_ENABLE]) | dir_sync_reg[1];

  always_comb begin
    wrap       = 1'b0;
    count_next = count_reg;
    if (step) begin
      if (up_dir) begin
        if (count_reg == ALL_ONES) begin
          wrap       = 1'b1;
          count_next = (op_mode == UDART_RELOAD) ? reload_reg : 16'h0000;
        end else begin
          count_next = count_reg + COUNT_ONE;
        end
      end else if (count_reg == reload_reg) begin
        wrap       = 1'b1;
        count_next = ALL_ONES;
      end else begin
        count_next = count_reg - COUNT_ONE;
      end
    end
  end

  // ************************************************************
  // Register writes and counting
  // ************************************************************
  // Bus writes to the count override a simultaneous count step.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      count_reg <= 16'h0000;
    end else if (wr_hit(BUS, ADDR_COUNT_LOW)) begin
      count_reg <= {count_reg[15:8], BUS.wdata};
    end else if (wr_hit(BUS, ADDR_COUNT_HIGH)) begin
      count_reg <= {BUS.wdata, count_reg[7:0]};
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      reload_reg <= 16'h0000;
      mode_reg   <= RESET_BYTE;
    end else if (BUS.wr) begin
      if (BUS.addr == ADDR_RELOAD_LOW) begin
        reload_reg[7:0] <= BUS.wdata;
      end
      if (BUS.addr == ADDR_RELOAD_HIGH) begin
        reload_reg[15:8] <= BUS.wdata;
      end
      if (BUS.addr == ADDR_MODE) begin
        mode_reg <= {7'h00, BUS.wdata[MODE_DOWN_COUNT_ENABLE]};
      end
    end
  end

  // Flags are set by hardware; a set in the same cycle as a clear wins.
  logic down_count_enable_active;
  assign down_count_enable_active = (op_mode == UDART_RELOAD) && mode_reg[MODE_DOWN_COUNT_ENABLE];
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      ctl_reg <= RESET_BYTE;
    end else begin
      if (wr_hit(BUS, ADDR_CONTROL)) begin
        ctl_reg <= BUS.wdata & ~(8'h01 << CTL_RSVD);
      end
      if (wrap) begin
        ctl_reg[CTL_OVF] <= 1'b1;
        if (down_count_enable_active) begin
          ctl_reg[CTL_TOGGLE] <= wr_hit(BUS, ADDR_CONTROL) ?
                                 ~BUS.wdata[CTL_TOGGLE] : ~ctl_reg[CTL_TOGGLE];
        end
      end
    end
  end

  // ************************************************************
  // Read data and outputs
  // ************************************************************
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
    end else if (BUS.rd) begin
      case (BUS.addr)
        ADDR_CONTROL:     RDATA <= ctl_reg;
        ADDR_MODE:        RDATA <= mode_reg;
        ADDR_COUNT_LOW:   RDATA <= count_reg[7:0];
        ADDR_COUNT_HIGH:  RDATA <= count_reg[15:8];
        ADDR_RELOAD_LOW:  RDATA <= reload_reg[7:0];
        ADDR_RELOAD_HIGH: RDATA <= reload_reg[15:8];
        default:          RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  // The toggle flag never reaches the interrupt line.
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ   <= 1'b0;
      COUNT <= 16'h0000;
    end else begin
      IRQ   <= ctl_reg[CTL_OVF];
      COUNT <= count_reg;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  sequence up_wrap_s;
    step && up_dir && count_reg == ALL_ONES && !BUS.wr;
  endsequence
  sequence down_wrap_s;
    step && !up_dir && count_reg == reload_reg && !BUS.wr;
  endsequence

  AST_UP_RELOAD: assert property (@(posedge CLOCK) disable iff (!RST_B)
    up_wrap_s and (op_mode == UDART_RELOAD) |=> count_reg == $past(reload_reg))
    else $error("up overflow did not reload");
  AST_DOWN_ONES: assert property (@(posedge CLOCK) disable iff (!RST_B)
    down_wrap_s |=> count_reg == ALL_ONES)
    else $error("underflow did not load all ones");
  AST_OVF_SET: assert property (@(posedge CLOCK) disable iff (!RST_B)
    (up_wrap_s or down_wrap_s) |=> ctl_reg[CTL_OVF] ##1 IRQ)
    else $error("overflow flag or interrupt missing");
  AST_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !ctl_reg[CTL_RUN] && !BUS.wr |=> count_reg == $past(count_reg))
    else $error("count moved while stopped");
  AST_UP_STEP: assert property (@(posedge CLOCK) disable iff (!RST_B)
    step && up_dir && count_reg != ALL_ONES && !BUS.wr |=>
    count_reg == $past(count_reg) + COUNT_ONE)
    else $error("up step wrong");
  AST_DIR_IGNORED: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !mode_reg[MODE_DOWN_COUNT_ENABLE] |-> up_dir)
    else $error("direction used without down enable");
  AST_TOGGLE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    down_count_enable_active && wrap && !BUS.wr |=> ctl_reg[CTL_TOGGLE] != $past(ctl_reg[CTL_TOGGLE]))
    else $error("toggle flag did not invert");
  AST_PRESCALE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    pre_tick |=> !pre_tick [*2])
    else $error("prescaler ticked too often");
  AST_DOWN_CMP: assert property (@(posedge CLOCK) disable iff (!RST_B)
    step && !up_dir && count_reg != reload_reg |-> !wrap)
    else $error("underflow without match");
  AST_MODE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    ctl_reg[CTL_TRANSMIT_CLOCK_SELECT] |-> op_mode == UDART_BAUD)
    else $error("mode decode wrong");
  AST_DIR_USED: assert property (@(posedge CLOCK) disable iff (!RST_B)
    down_count_enable_active |-> up_dir == dir_sync_reg[1])
    else $error("direction pin ignored");

  // ************************************************************
  // Input selection, register writes and flags
  // ************************************************************
  // Capture and baud modes only free-run here; their own paths are not built.
  sequence pin_down_step_s;
    down_count_enable_active && !dir_sync_reg[1] && step && count_reg != reload_reg && !BUS.wr;
  endsequence

  AST_DOWN_STEP: assert property (@(posedge CLOCK) disable iff (!RST_B)
    pin_down_step_s |=> count_reg == $past(count_reg) - COUNT_ONE)
    else $error("down step wrong");
  AST_TIMER_INPUT: assert property (@(posedge CLOCK) disable iff (!RST_B)
    ctl_reg[CTL_RUN] && !ctl_reg[CTL_CT_SEL] && !pre_tick && !BUS.wr |=>
    $stable(count_reg))
    else $error("count moved without a prescaler tick");
  AST_PIN_INPUT: assert property (@(posedge CLOCK) disable iff (!RST_B)
    ctl_reg[CTL_RUN] && ctl_reg[CTL_CT_SEL] && !pin_event && !BUS.wr |=>
    $stable(count_reg))
    else $error("count moved without a pin edge");
  AST_PIN_ONCE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    pin_event |=> !pin_event)
    else $error("one pin edge counted twice");
  AST_STOP_NO_WRAP: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !ctl_reg[CTL_RUN] |-> !wrap)
    else $error("wrap while stopped");
  AST_OTHER_WRAP: assert property (@(posedge CLOCK) disable iff (!RST_B)
    up_wrap_s and (op_mode != UDART_RELOAD) |=>
    count_reg == 16'h0000)
    else $error("free-running mode did not wrap to zero");
  AST_MODE_RELOAD: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !ctl_reg[CTL_RCLK] && !ctl_reg[CTL_TRANSMIT_CLOCK_SELECT] && !ctl_reg[CTL_CP_RL] |->
    op_mode == UDART_RELOAD)
    else $error("reload mode decode wrong");
  AST_MODE_CAPTURE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !ctl_reg[CTL_RCLK] && !ctl_reg[CTL_TRANSMIT_CLOCK_SELECT] && ctl_reg[CTL_CP_RL] |->
    op_mode == UDART_CAPTURE)
    else $error("capture mode decode wrong");
  AST_MODE_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_B)
    wr_hit(BUS, ADDR_MODE) |=> mode_reg[MODE_DOWN_COUNT_ENABLE] == $past(BUS.wdata[MODE_DOWN_COUNT_ENABLE]))
    else $error("down enable write lost");
  AST_COUNT_WR_LOW: assert property (@(posedge CLOCK) disable iff (!RST_B)
    wr_hit(BUS, ADDR_COUNT_LOW) |=> count_reg[7:0] == $past(BUS.wdata))
    else $error("count low write lost");
  AST_COUNT_WR_HIGH: assert property (@(posedge CLOCK) disable iff (!RST_B)
    wr_hit(BUS, ADDR_COUNT_HIGH) |=> count_reg[15:8] == $past(BUS.wdata))
    else $error("count high write lost");
  AST_RELOAD_WR_LOW: assert property (@(posedge CLOCK) disable iff (!RST_B)
    wr_hit(BUS, ADDR_RELOAD_LOW) |=> reload_reg[7:0] == $past(BUS.wdata))
    else $error("reload low write lost");
  AST_RELOAD_WR_HIGH: assert property (@(posedge CLOCK) disable iff (!RST_B)
    wr_hit(BUS, ADDR_RELOAD_HIGH) |=> reload_reg[15:8] == $past(BUS.wdata))
    else $error("reload high write lost");
  AST_FLAG_STICKY: assert property (@(posedge CLOCK) disable iff (!RST_B)
    ctl_reg[CTL_OVF] && !wr_hit(BUS, ADDR_CONTROL) |=> ctl_reg[CTL_OVF])
    else $error("overflow flag cleared without a write");
  AST_TOGGLE_QUIET: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !(wrap && down_count_enable_active) && !wr_hit(BUS, ADDR_CONTROL) |=> $stable(ctl_reg[CTL_TOGGLE]))
    else $error("toggle flag moved without a wrap");
  AST_IRQ_FOLLOW: assert property (@(posedge CLOCK) disable iff (!RST_B)
    1'b1 |=> IRQ == $past(ctl_reg[CTL_OVF]))
    else $error("interrupt not driven by the overflow flag alone");
  AST_COUNT_COPY: assert property (@(posedge CLOCK) disable iff (!RST_B)
    1'b1 |=> COUNT == $past(count_reg))
    else $error("count output does not follow the count");

endmodule

// File: test/udart_pin_model.sv
`timescale 1ns/1ps
module udart_pin_model (
  // Clock
  input  wire logic CLOCK,
  // Pins
  output logic      count_pin,
  output logic      dir_pin
);
  initial begin
    count_pin = 1'b1;
    dir_pin   = 1'b1;
  end
  // Three cycles per level, so the synchroniser always sees the edge.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge CLOCK);
      count_pin <= 1'b0;
      repeat (3) @(posedge CLOCK);
      count_pin <= 1'b1;
      repeat (3) @(posedge CLOCK);
    end
  endtask
  task automatic set_dir(input logic up);
    @(posedge CLOCK);
    dir_pin <= up;
    repeat (4) @(posedge CLOCK);
  endtask
endmodule

// File: test/udart_timer_test.sv
`timescale 1ns/1ps
module udart_timer_test;
  import udart_pkg::*;
  localparam int DIV = 4;
  logic        CLOCK;
  logic        RST_B;
  udart_bus_t  bus;
  logic [7:0]  rdata;
  logic        count_pin;
  logic        dir_pin;
  logic        irq;
  logic [15:0] count;
  logic [7:0]  ctl [3];
  int          fails;
  int          checked;
  int          cycles;
  udart_timer #(.PRESCALE_DIV(DIV)) i_udart_timer (.CLOCK(CLOCK), .RST_B(RST_B), .BUS(bus),
    .RDATA(rdata), .COUNT_PIN(count_pin), .DIR_PIN(dir_pin), .IRQ(irq), .COUNT(count));
  udart_pin_model i_udart_pin_model (.CLOCK(CLOCK), .count_pin(count_pin), .dir_pin(dir_pin));
  // ************************************************************
  // Bus tasks and comparison
  // ************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CLOCK);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge CLOCK);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge CLOCK);
    bus.rd <= 1'b0;
    #1 check({8'h00, rdata}, {8'h00, exp});
  endtask
  task automatic rd16(input logic [15:0] exp);
    rd(ADDR_COUNT_LOW, exp[7:0]);
    rd(ADDR_COUNT_HIGH, exp[15:8]);
  endtask
  task automatic load(input logic [15:0] c, input logic [15:0] r);
    wr(ADDR_COUNT_LOW, c[7:0]);
    wr(ADDR_COUNT_HIGH, c[15:8]);
    wr(ADDR_RELOAD_LOW, r[7:0]);
    wr(ADDR_RELOAD_HIGH, r[15:8]);
  endtask
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end
  // The whole sequence needs a few hundred cycles; the ceiling leaves ample slack.
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    bus = '0;
    RST_B = 1'b0;
    fails = 0;
    checked = 0;
    cycles = 0;
    ctl = '{8'h07, 8'h26, 8'h16};
    repeat (3) @(posedge CLOCK);
    RST_B <= 1'b1;
    wr(4'h6, 8'h5a);
    for (int a = 0; a < 7; a++) rd(a[3:0], 8'h00);
    wr(ADDR_CONTROL, 8'h02);
    i_udart_pin_model.pulse(3);
    rd16(16'h0000);
    wr(ADDR_CONTROL, 8'h04);
    repeat (40) @(posedge CLOCK);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_LOW, 8'h0a);
    check({15'h0000, count >= 16'd9 && count <= 16'd11}, 16'h0001);
    load(16'h00fe, 16'h1234);
    wr(ADDR_CONTROL, 8'h06);
    i_udart_pin_model.pulse(3);
    rd16(16'h0101);
    wr(ADDR_CONTROL, 8'h00);
    load(16'hfffe, 16'h1234);
    i_udart_pin_model.set_dir(1'b0);
    wr(ADDR_CONTROL, 8'h06);
    i_udart_pin_model.pulse(2);
    rd16(16'h1234);
    check(count, 16'h1234);
    rd(ADDR_CONTROL, 8'h86);
    check({15'h0000, irq}, 16'h0001);
    wr(ADDR_CONTROL, 8'h06);
    repeat (3) @(posedge CLOCK);
    check({15'h0000, irq}, 16'h0000);
    rd(ADDR_CONTROL, 8'h06);
    wr(ADDR_MODE, 8'h01);
    load(16'h1236, 16'h1234);
    i_udart_pin_model.pulse(2);
    rd16(16'h1234);
    i_udart_pin_model.pulse(1);
    rd16(16'hffff);
    rd(ADDR_CONTROL, 8'hc6);
    wr(ADDR_CONTROL, 8'h46);
    repeat (3) @(posedge CLOCK);
    check({15'h0000, irq}, 16'h0000);
    i_udart_pin_model.set_dir(1'b1);
    i_udart_pin_model.pulse(1);
    rd16(16'h1234);
    rd(ADDR_CONTROL, 8'h86);
    wr(ADDR_MODE, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CONTROL, 8'h00);
      load(16'hfffe, 16'h1234);
      wr(ADDR_CONTROL, ctl[i]);
      i_udart_pin_model.pulse(2);
      rd16(16'h0000);
    end
    conclude();
  end
endmodule
